//--- include/sssr_pkg.sv
package sssr_pkg;
  // Register byte addresses on the Wishbone bus
  localparam logic [7:0] ADR_CTRL     = 8'h80;
  localparam logic [7:0] ADR_BUF      = 8'h84;
  localparam logic [7:0] ADR_IRQ_ST   = 8'h88;
  localparam logic [7:0] ADR_IRQ_MSK  = 8'h8C;
  localparam logic [7:0] ADR_SLV_ADDR = 8'h90;
  localparam logic [7:0] ADR_STATUS   = 8'h94;
  // Control fields
  localparam int CTL_EN  = 0;
  localparam int CTL_MST = 1;
  localparam int CTL_TW  = 2;
  localparam int CTL_RWV = 3;
  localparam int CTL_W   = 3;
  // Interrupt status fields
  localparam int IRQ_BYTE  = 0;
  localparam int IRQ_START = 1;
  localparam int IRQ_STOP  = 2;
  localparam int IRQ_W     = 3;
  // Reset values
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [2:0] CTL_RST    = 3'h0;
  // Master bit timing: one quarter of a bit, rounded up to clocks
  localparam int CLK_NS      = 40;
  localparam int MST_QTR_NS  = 80;
  localparam int MST_QTR_CYC = (MST_QTR_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] QTR_LAST = 4'(MST_QTR_CYC - 1);
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Status register layout, bit 7 down to bit 0
  typedef struct packed {
    logic input_sample_phase;
    logic clk_edge_sel;
    logic data_addr;
    logic stop_seen;
    logic start_seen;
    logic rd_wr;
    logic update_addr_flag;
    logic buffer_full;
  } sssr_status_s;

  // Event pulses from the two-wire sequencer
  typedef struct packed {
    logic addr_match;
    logic rw_bit;
    logic data_byte;
    logic addr_byte;
    logic ack;
    logic rx_byte;
    logic tx_done;
    logic addr_update;
  } sssr_tw_ev_s;

  typedef enum logic {M_IDLE, M_RUN} sssr_mst_e;
endpackage

//--- logic/sssr_port.sv
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Master samples mid or end per phase
// - Two-wire data/address flag tracks last byte
// - Stop flag set on stop, cleared
// - Start flag set on start, cleared
// - Read/write bit captured on address match
// - Read/write valid until start/stop/ack
// - Update-address flag requests address reload
// - Buffer full set on received byte
// - Two-wire transmit holds buffer full
// - Completed SPI byte or two-wire received byte raises port interrupt flag
module sssr_port (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [31:0]           wb_dat_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic                  wb_we_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  // SPI pins
  input  wire logic                  sck_i,
  input  wire logic                  sdi_i,
  input  wire logic                  ss_n_i,
  output logic                       sck_o,
  output logic                       sck_oe_o,
  output logic                       sdo_o,
  output logic                       sdo_oe_o,
  // Two-wire pins, watched for start and stop
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  // Two-wire sequencer events
  input  wire sssr_pkg::sssr_tw_ev_s tw_ev_i,
  input  wire logic [7:0]            tw_rx_data_i,
  // Interrupt
  output logic                       irq_o
);

  logic [4:0]           meta_q;
  logic [4:0]           sync_q;
  logic [4:0]           pins;
  logic                 sck_p_q;
  logic                 scl_p_q;
  logic                 sda_p_q;
  logic [2:0]           ctrl_q;
  logic                 rw_valid_q;
  logic [7:0]           slv_addr_q;
  logic [7:0]           rx_buf_q;
  logic [7:0]           shreg_q;
  logic [2:0]           bitcnt_q;
  logic [1:0]           phase_q;
  logic [3:0]           qcnt_q;
  logic                 rx_bit_q;
  logic                 byte_done_q;
  logic [2:0]           irq_st_q;
  logic [2:0]           irq_msk_q;
  sssr_pkg::sssr_mst_e  mst_q;
  sssr_pkg::sssr_status_s st_q;

  // Pin order in the synchroniser
  assign pins = {sck_i, sdi_i, ss_n_i, scl_i, sda_i};

  // Two flops per pin; only sync_q is looked at
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
        end else begin
          meta_q[g] <= pins[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  logic sck_s;
  logic sdi_s;
  logic ss_n_s;
  logic scl_s;
  logic sda_s;
  assign {sck_s, sdi_s, ss_n_s, scl_s, sda_s} = sync_q;

  // Previous samples for edge finding
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_p_q <= 1'b0;
      scl_p_q <= 1'b0;
      sda_p_q <= 1'b0;
    end else begin
      sck_p_q <= sck_s;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  logic en;
  logic mst;
  logic tw_on;
  logic sck_rise;
  logic sck_fall;
  logic samp_edge;
  logic out_edge;
  logic tw_start;
  logic tw_stop;
  assign en        = ctrl_q[sssr_pkg::CTL_EN];
  assign mst       = ctrl_q[sssr_pkg::CTL_MST];
  assign tw_on     = en & ctrl_q[sssr_pkg::CTL_TW];
  assign sck_rise  = sck_s & ~sck_p_q;
  assign sck_fall  = ~sck_s & sck_p_q;
  // Edge select swaps which slave edge samples
  assign samp_edge = st_q.clk_edge_sel ? sck_fall : sck_rise;
  assign out_edge  = st_q.clk_edge_sel ? sck_rise : sck_fall;
  // Data moving while the clock line is high frames a message
  assign tw_start  = tw_on & scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign tw_stop   = tw_on & scl_s & scl_p_q & ~sda_p_q & sda_s;

  // Bus decode; one request per ack, ack drops next cycle
  logic req;
  logic wr;
  logic rd;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr  = req & wb_we_i & wb_sel_i[0];
  assign rd  = req & ~wb_we_i;

  logic wr_ctrl;
  logic wr_buf;
  logic wr_st;
  logic wr_slv;
  logic rd_buf;
  assign wr_ctrl = wr & (wb_adr_i == sssr_pkg::ADR_CTRL);
  assign wr_buf  = wr & (wb_adr_i == sssr_pkg::ADR_BUF);
  assign wr_st   = wr & (wb_adr_i == sssr_pkg::ADR_STATUS);
  assign wr_slv  = wr & (wb_adr_i == sssr_pkg::ADR_SLV_ADDR);
  assign rd_buf  = rd & (wb_adr_i == sssr_pkg::ADR_BUF);

  // Ack one cycle after the strobe, unmapped included
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Read data, registered so it is stable with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd) begin
      case (wb_adr_i)
        sssr_pkg::ADR_CTRL:     wb_dat_o <= {28'h000_0000,
                                             rw_valid_q, ctrl_q};
        sssr_pkg::ADR_BUF:      wb_dat_o <= {24'h00_0000, rx_buf_q};
        sssr_pkg::ADR_IRQ_ST:   wb_dat_o <= {29'h0000_0000, irq_st_q};
        sssr_pkg::ADR_IRQ_MSK:  wb_dat_o <= {29'h0000_0000, irq_msk_q};
        sssr_pkg::ADR_SLV_ADDR: wb_dat_o <= {24'h00_0000, slv_addr_q};
        sssr_pkg::ADR_STATUS:   wb_dat_o <= {24'h00_0000, st_q};
        default:                wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Control and slave address registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q     <= sssr_pkg::CTL_RST;
      slv_addr_q <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wb_dat_i[2:0];
      end
      if (wr_slv) begin
        slv_addr_q <= wb_dat_i[7:0];
      end
    end
  end

  // Shift engine, shared by master and slave; a buffer write
  // during a byte restarts it, software must wait for the flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shreg_q     <= 8'h00;
      bitcnt_q    <= 3'h0;
      phase_q     <= 2'h0;
      qcnt_q      <= 4'h0;
      rx_bit_q    <= 1'b0;
      sck_o       <= 1'b0;
      sdo_o       <= 1'b0;
      byte_done_q <= 1'b0;
      mst_q       <= sssr_pkg::M_IDLE;
    end else begin
      byte_done_q <= 1'b0;
      if (!en || tw_on) begin
        mst_q    <= sssr_pkg::M_IDLE;
        bitcnt_q <= 3'h0;
        sck_o    <= 1'b0;
      end else if (wr_buf) begin
        shreg_q  <= wb_dat_i[7:0];
        sdo_o    <= wb_dat_i[7];
        bitcnt_q <= 3'h0;
        phase_q  <= 2'h0;
        qcnt_q   <= 4'h0;
        if (mst) begin
          mst_q <= sssr_pkg::M_RUN;
        end
      end else if (mst) begin
        case (mst_q)
          sssr_pkg::M_RUN: begin
            if (qcnt_q == sssr_pkg::QTR_LAST) begin
              qcnt_q  <= 4'h0;
              phase_q <= phase_q + 2'h1;
              case (phase_q)
                2'h0: sdo_o <= shreg_q[7];
                2'h1: begin
                  sck_o <= 1'b1;
                  if (!st_q.input_sample_phase) begin
                    rx_bit_q <= sdi_s;
                  end
                end
                2'h3: begin
                  sck_o    <= 1'b0;
                  shreg_q  <= {shreg_q[6:0], st_q.input_sample_phase
                                             ? sdi_s : rx_bit_q};
                  bitcnt_q <= bitcnt_q + 3'h1;
                  if (bitcnt_q == sssr_pkg::LAST_BIT) begin
                    byte_done_q <= 1'b1;
                    mst_q       <= sssr_pkg::M_IDLE;
                  end
                end
                default: ;
              endcase
            end else begin
              qcnt_q <= qcnt_q + 4'h1;
            end
          end
          default: mst_q <= sssr_pkg::M_IDLE;
        endcase
      end else if (!ss_n_s) begin
        // last bit latched ends the byte
        if (samp_edge) begin
          shreg_q  <= {shreg_q[6:0], sdi_s};
          bitcnt_q <= bitcnt_q + 3'h1;
          if (bitcnt_q == sssr_pkg::LAST_BIT) begin
            byte_done_q <= 1'b1;
          end
        end else if (out_edge) begin
          sdo_o <= shreg_q[7];
        end
      end
    end
  end

  // Pin drivers; the slave lets the data line float when deselected
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_oe_o <= 1'b0;
      sdo_oe_o <= 1'b0;
    end else begin
      sck_oe_o <= en & mst & ~tw_on;
      sdo_oe_o <= en & ~tw_on & (mst | ~ss_n_s);
    end
  end

  // Receive buffer loads from whichever mode finished a byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_buf_q <= 8'h00;
    end else if (byte_done_q) begin
      rx_buf_q <= shreg_q;
    end else if (tw_on && tw_ev_i.rx_byte) begin
      rx_buf_q <= tw_rx_data_i;
    end
  end

  // Writable status fields; slave mode ignores the sample
  // phase, only the master engine reads it
  // sample phase kept by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q.input_sample_phase <= sssr_pkg::STATUS_RST[7];
      st_q.clk_edge_sel       <= sssr_pkg::STATUS_RST[6];
    end else if (wr_st) begin
      st_q.input_sample_phase <= wb_dat_i[7];
      st_q.clk_edge_sel       <= wb_dat_i[6];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q.data_addr <= sssr_pkg::STATUS_RST[5];
    end else if (tw_on && tw_ev_i.data_byte) begin
      st_q.data_addr <= 1'b1;
    end else if (tw_on && tw_ev_i.addr_byte) begin
      st_q.data_addr <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !en) begin
      st_q.stop_seen  <= 1'b0;
      st_q.start_seen <= 1'b0;
    end else if (tw_stop) begin
      st_q.stop_seen  <= 1'b1;
      st_q.start_seen <= 1'b0;
    end else if (tw_start) begin
      st_q.start_seen <= 1'b1;
      st_q.stop_seen  <= 1'b0;
    end
  end

  // direction bit and its validity window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q.rd_wr <= sssr_pkg::STATUS_RST[2];
      rw_valid_q <= 1'b0;
    end else if (tw_on && tw_ev_i.addr_match) begin
      st_q.rd_wr <= tw_ev_i.rw_bit;
      rw_valid_q <= 1'b1;
    end else if (tw_start || tw_stop || (tw_on && tw_ev_i.ack)) begin
      rw_valid_q <= 1'b0;
    end
  end

  // address reload request, set beats clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q.update_addr_flag <= sssr_pkg::STATUS_RST[1];
    end else if (tw_on && tw_ev_i.addr_update) begin
      st_q.update_addr_flag <= 1'b1;
    end else if (wr_slv) begin
      st_q.update_addr_flag <= 1'b0;
    end
  end

  // buffer full, any set wins over a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q.buffer_full <= sssr_pkg::STATUS_RST[0];
    end else if (byte_done_q || (tw_on && tw_ev_i.rx_byte)
                 || (wr && tw_on && wb_adr_i == sssr_pkg::ADR_BUF)) begin
      st_q.buffer_full <= 1'b1;
    end else if (rd_buf || (tw_on && tw_ev_i.tx_done)) begin
      st_q.buffer_full <= 1'b0;
    end
  end

  // Interrupt events: byte done, start, stop
  logic [2:0] irq_set;
  assign irq_set = {tw_stop, tw_start,
                    byte_done_q | (tw_on & tw_ev_i.rx_byte)};

  // sticky flags, write one to clear, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_q  <= 3'h0;
      irq_msk_q <= 3'h0;
      irq_o     <= 1'b0;
    end else begin
      irq_st_q <= irq_set | (irq_st_q & ~((wr && wb_adr_i ==
                  sssr_pkg::ADR_IRQ_ST) ? wb_dat_i[2:0] : 3'h0));
      if (wr && wb_adr_i == sssr_pkg::ADR_IRQ_MSK) begin
        irq_msk_q <= wb_dat_i[2:0];
      end
      irq_o <= |(irq_st_q & irq_msk_q); // One cycle behind the flags
    end
  end

  // Checks
  a_mid_sample: assert property (@(posedge clk_i)
    disable iff (rst_i) $rose(sck_o) && !st_q.input_sample_phase
    |-> rx_bit_q == $past(sdi_s)) else $error("middle sample missed");
  a_data_kind: assert property (@(posedge clk_i)
    disable iff (rst_i) tw_on && tw_ev_i.data_byte |=> st_q.data_addr)
    else $error("data flag not set");
  a_stop_flag: assert property (@(posedge clk_i)
    disable iff (rst_i) en && tw_stop |=> st_q.stop_seen && !st_q.start_seen)
    else $error("stop flag wrong");
  a_start_flag: assert property (@(posedge clk_i)
    disable iff (rst_i) en && tw_start && !tw_stop
    |=> st_q.start_seen && !st_q.stop_seen) else $error("start flag wrong");
  a_rw_capture: assert property (@(posedge clk_i)
    disable iff (rst_i) tw_on && tw_ev_i.addr_match |=>
    st_q.rd_wr == $past(tw_ev_i.rw_bit)) else $error("direction lost");
  a_rw_window: assert property (@(posedge clk_i)
    disable iff (rst_i) (tw_start || tw_stop) && !tw_ev_i.addr_match
    |=> !rw_valid_q) else $error("direction still valid");
  a_ua_set: assert property (@(posedge clk_i)
    disable iff (rst_i) tw_on && tw_ev_i.addr_update |=>
    st_q.update_addr_flag) else $error("update flag not set");
  a_bf_rx: assert property (@(posedge clk_i)
    disable iff (rst_i) byte_done_q |=> st_q.buffer_full
    && rx_buf_q == $past(shreg_q)) else $error("byte not held");
  a_bf_tx: assert property (@(posedge clk_i)
    disable iff (rst_i) tw_on && tw_ev_i.tx_done && !tw_ev_i.rx_byte
    && !wr && !byte_done_q |=> !st_q.buffer_full)
    else $error("transmit full stuck");
  a_byte_irq: assert property (@(posedge clk_i)
    disable iff (rst_i) byte_done_q |=> irq_st_q[sssr_pkg::IRQ_BYTE]
    ##1 (irq_o || !$past(irq_msk_q[sssr_pkg::IRQ_BYTE])))
    else $error("byte irq missing");
  a_rd_clear: assert property (@(posedge clk_i)
    disable iff (rst_i) rd_buf && !byte_done_q
    && !(tw_on && tw_ev_i.rx_byte) |=> !st_q.buffer_full)
    else $error("read did not clear");

endmodule // sssr_port
`default_nettype wire

//--- verification/sssr_spi_peer.sv
`timescale 1ns/1ps
`default_nettype none
// Far side of the port: SPI master or slave, and two-wire line driver
module sssr_spi_peer #(
  parameter logic [7:0] PAT_MID = 8'h96,
  parameter logic [7:0] PAT_END = 8'h69
) (
  // Clock and master-side pins of the port
  input  wire logic       clk_i,
  input  wire logic       sck_m_i,
  input  wire logic       sck_oe_m_i,
  input  wire logic       sdo_m_i,
  // Lines driven into the port
  output logic            sck_o,
  output logic            sdi_o,
  output logic            ss_n_o,
  output logic            scl_o,
  output logic            sda_o,
  // Byte shifted out by the port as master
  output logic [7:0]      mosi_o
);
  logic [2:0] bit_q;
  logic       sck_d_q;

  // Idle levels; two-wire lines have pull-ups
  initial begin
    sck_o = 1'b0;
    sdi_o = 1'b0;
    ss_n_o = 1'b1;
    scl_o = 1'b1;
    sda_o = 1'b1;
    mosi_o = 8'h00;
    bit_q = 3'h0;
    sck_d_q = 1'b0;
  end

  // Prepare for a master byte from the port
  task automatic arm;
    bit_q <= 3'h0;
    mosi_o <= 8'h00;
    sdi_o <= PAT_MID[7];
  endtask

  // As slave: data changes as sck rises, just after the mid-bit sample, so the two
  // sample points see different bits and the phase is observable
  // sample point
  always @(posedge clk_i) begin
    sck_d_q <= sck_m_i;
    if (sck_oe_m_i && sck_m_i && !sck_d_q) begin
      mosi_o <= {mosi_o[6:0], sdo_m_i};
      sdi_o <= PAT_END[3'd7 - bit_q];
    end
    if (sck_oe_m_i && !sck_m_i && sck_d_q) begin
      bit_q <= bit_q + 3'd1;
      sdi_o <= PAT_MID[3'd6 - bit_q];
    end
  end

  // As master: 320 ns link clock, free of the system clock phase;
  // sck stands low outside the frame and data is scrambled after it.
  // Data moves on the edge opposite the one the port samples on
  task automatic spi_send(input logic [7:0] b, input logic ce);
    #13 ss_n_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (!ce) sdi_o = b[i];
      #160 sck_o = 1'b1;
      if (ce) sdi_o = b[i];
      #160 sck_o = 1'b0;
    end
    #160 ss_n_o = 1'b1;
    sdi_o = ~sdi_o;
  endtask

  // Start: data falls while clock is high; kept off the clock edges
  task automatic tw_start;
    #7 sda_o = 1'b1;
    #200 scl_o = 1'b1;
    #200 sda_o = 1'b0;
    #200 scl_o = 1'b0;
  endtask

  // Stop: data rises while clock is high
  task automatic tw_stop;
    #7 sda_o = 1'b0;
    #200 scl_o = 1'b1;
    #200 sda_o = 1'b1;
    #200;
  endtask
endmodule // sssr_spi_peer
`default_nettype wire

//--- verification/test_sync_serial_status_reg.sv
`timescale 1ns/1ps
`default_nettype none
module test_sync_serial_status_reg;
  logic                  clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i;
  logic [7:0]            wb_adr_i, tw_rx_data_i;
  logic [31:0]           wb_dat_i, wb_dat_o;
  logic [3:0]            wb_sel_i;
  logic                  wb_ack_o, irq_o, sck_o, sck_oe_o, sdo_o, sdo_oe_o;
  logic                  sck_i, sdi_i, ss_n_i, scl_i, sda_i;
  logic [7:0]            mosi;
  sssr_pkg::sssr_tw_ev_s tw_ev_i;
  int                    error_cnt, samples_checked;

  sssr_port dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sck_i(sck_i), .sdi_i(sdi_i), .ss_n_i(ss_n_i),
    .sck_o(sck_o), .sck_oe_o(sck_oe_o), .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o), .scl_i(scl_i), .sda_i(sda_i),
    .tw_ev_i(tw_ev_i), .tw_rx_data_i(tw_rx_data_i), .irq_o(irq_o));

  sssr_spi_peer peer (.clk_i(clk_i), .sck_m_i(sck_o),
    .sck_oe_m_i(sck_oe_o), .sdo_m_i(sdo_o), .sck_o(sck_i),
    .sdi_o(sdi_i), .ss_n_o(ss_n_i), .scl_o(scl_i), .sda_o(sda_i),
    .mosi_o(mosi));

  // Clock at 25 MHz
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic single cycle; held until ack is sampled, no fixed latency
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= {24'h00_0000, d};
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    if (n >= 50) chk("bus ack", 32'h0000_0001, 32'h0000_0000);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [31:0] q;
    wb(a, 1'b0, 8'h00, q);
    chk(nm, {24'h00_0000, e}, q);
  endtask

  task automatic sbit(input int b, input logic e, input string nm);
    logic [31:0] q;
    wb(sssr_pkg::ADR_STATUS, 1'b0, 8'h00, q);
    chk(nm, {31'h0000_0000, e}, {31'h0000_0000, q[b]});
  endtask

  task automatic irq_chk(input logic e);
    repeat (3) @(posedge clk_i);
    chk("irq", {31'h0000_0000, e}, {31'h0000_0000, irq_o});
  endtask

  // One-cycle sequencer event
  task automatic pulse(input logic [7:0] e);
    @(posedge clk_i);
    tw_ev_i <= sssr_pkg::sssr_tw_ev_s'(e);
    @(posedge clk_i);
    tw_ev_i <= sssr_pkg::sssr_tw_ev_s'(8'h00);
  endtask

  task automatic t_regs;
    rd(sssr_pkg::ADR_STATUS, 8'h00, "status reset");
    rd(sssr_pkg::ADR_CTRL, 8'h00, "ctrl reset");
    rd(8'hA0, 8'h00, "unmapped");
    wr(sssr_pkg::ADR_STATUS, 8'hFF);
    rd(sssr_pkg::ADR_STATUS, 8'hC0, "status writable");
    wr(sssr_pkg::ADR_STATUS, 8'h00);
    // A write without byte lane 0 is acked but ignored
    wb_sel_i <= 4'hE;
    wr(sssr_pkg::ADR_STATUS, 8'hFF);
    rd(sssr_pkg::ADR_STATUS, 8'h00, "lane 0 off");
    wb_sel_i <= 4'hF;
    $display("test regs done");
  endtask

  task automatic t_conditions;
    wr(sssr_pkg::ADR_CTRL, 8'h05);
    peer.tw_start();
    rd(sssr_pkg::ADR_STATUS, 8'h08, "start seen");
    rd(sssr_pkg::ADR_IRQ_ST, 8'h02, "start event");
    wr(sssr_pkg::ADR_IRQ_MSK, 8'h04);
    irq_chk(1'b0);
    wr(sssr_pkg::ADR_IRQ_MSK, 8'h02);
    irq_chk(1'b1);
    wr(sssr_pkg::ADR_IRQ_ST, 8'h02);
    irq_chk(1'b0);
    peer.tw_stop();
    rd(sssr_pkg::ADR_STATUS, 8'h10, "stop seen");
    peer.tw_start();
    rd(sssr_pkg::ADR_STATUS, 8'h08, "start after stop");
    wr(sssr_pkg::ADR_CTRL, 8'h00);
    rd(sssr_pkg::ADR_STATUS, 8'h00, "disabled");
    wr(sssr_pkg::ADR_IRQ_ST, 8'h07);
    $display("test conditions done");
  endtask

  task automatic t_events;
    wr(sssr_pkg::ADR_CTRL, 8'h05);
    pulse(8'hC0);
    sbit(2, 1'b1, "read flag");
    rd(sssr_pkg::ADR_CTRL, 8'h0D, "rw valid");
    pulse(8'h08);
    rd(sssr_pkg::ADR_CTRL, 8'h05, "ack ends valid");
    pulse(8'h80);
    sbit(2, 1'b0, "write flag");
    peer.tw_start();
    rd(sssr_pkg::ADR_CTRL, 8'h05, "start ends valid");
    pulse(8'h20);
    sbit(5, 1'b1, "data flag");
    pulse(8'h10);
    sbit(5, 1'b0, "address flag");
    pulse(8'h01);
    sbit(1, 1'b1, "update request");
    wr(sssr_pkg::ADR_SLV_ADDR, 8'h42);
    sbit(1, 1'b0, "update done");
    tw_rx_data_i <= 8'h5A;
    pulse(8'h04);
    sbit(0, 1'b1, "rx full");
    rd(sssr_pkg::ADR_BUF, 8'h5A, "rx data");
    sbit(0, 1'b0, "read empties");
    wr(sssr_pkg::ADR_BUF, 8'h33);
    sbit(0, 1'b1, "tx busy");
    pulse(8'h02);
    sbit(0, 1'b0, "tx complete");
    peer.tw_stop();
    wr(sssr_pkg::ADR_CTRL, 8'h00);
    wr(sssr_pkg::ADR_IRQ_ST, 8'h07);
    $display("test events done");
  endtask

  // Slave byte with either clock edge select
  task automatic t_slave(input logic ce, input logic [7:0] b);
    wr(sssr_pkg::ADR_STATUS, {1'b0, ce, 6'h00});
    wr(sssr_pkg::ADR_IRQ_MSK, 8'h01);
    wr(sssr_pkg::ADR_CTRL, 8'h01);
    peer.spi_send(b, ce);
    repeat (8) @(posedge clk_i);
    sbit(0, 1'b1, "slave full");
    rd(sssr_pkg::ADR_IRQ_ST, 8'h01, "slave byte event");
    irq_chk(1'b1);
    chk("slave pins", 32'h0000_0000, {30'h0000_0000, sck_oe_o, sdo_oe_o});
    rd(sssr_pkg::ADR_BUF, b, "slave data");
    wr(sssr_pkg::ADR_IRQ_ST, 8'h01);
    $display("test slave edge %0d done", ce);
  endtask

  // Peer offers 8'h96 before mid-bit and 8'h69 after it
  task automatic t_master(input logic ph);
    logic [31:0] q;
    int n;
    wr(sssr_pkg::ADR_STATUS, {ph, 7'h00});
    wr(sssr_pkg::ADR_CTRL, 8'h03);
    peer.arm();
    wr(sssr_pkg::ADR_BUF, 8'hC5);
    n = 0;
    q = 32'h0000_0000;
    while (q[0] !== 1'b1 && n < 60) begin
      wb(sssr_pkg::ADR_STATUS, 1'b0, 8'h00, q);
      n++;
    end
    rd(sssr_pkg::ADR_BUF, ph ? 8'h69 : 8'h96, "master rx");
    chk("master tx", 32'h0000_00C5, {24'h00_0000, mosi});
    chk("master pins", 32'h0000_0003,
        {29'h0000_0000, sck_o, sck_oe_o, sdo_oe_o});
    $display("test master phase %0d done", ph);
  endtask

  // Cut a hang short
  initial begin
    repeat (30000) @(posedge clk_i);
    error_cnt++;
    $display("ERROR watchdog expected end seen hang");
    finish_test();
  end

  // Reset, then the scenarios in turn
  initial begin
    error_cnt = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0000_0000;
    wb_sel_i = 4'hF;
    wb_we_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    tw_ev_i = sssr_pkg::sssr_tw_ev_s'(8'h00);
    tw_rx_data_i = 8'h00;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_conditions();
    t_events();
    t_slave(1'b0, 8'hA5);
    t_slave(1'b1, 8'h3C);
    t_master(1'b0);
    t_master(1'b1);
    finish_test();
  end
endmodule // test_sync_serial_status_reg
`default_nettype wire
